// ### common/sld_pkg.sv
// Constants shared by the serial latched driver logic
`default_nettype none
package sld_pkg;
    localparam int WIDTH = 12;
    localparam int SYNC_STAGES = 2;
    localparam logic [11:0] RESET_VALUE = 12'h000;
    localparam int LAST_STAGE = WIDTH - 1;
    localparam int BUF_DEPTH = 2;
endpackage
`default_nettype wire

// ### core/sld_buf.sv
// Two-entry buffer carrying captured serial bits into the shift register
`default_nettype none
module sld_buf (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_data
);
    logic [1:0] mem;
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    logic do_wr;
    logic do_rd;

    assign in_ready = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data = mem[rd_ptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (do_wr) begin
                wr_ptr <= ~wr_ptr;
            end
            if (do_rd) begin
                rd_ptr <= ~rd_ptr;
            end
            if (do_wr && !do_rd) begin
                count <= count + 2'h1;
            end else if (do_rd && !do_wr) begin
                count <= count - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ### core/sld_core.sv
// Serial-input latched driver: shift register, strobe latches, blanking
`default_nettype none
module sld_core (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SHIFT_CLK,
    input wire logic SERIAL_IN,
    input wire logic LATCH_STROBE,
    input wire logic OUTPUT_BLANK,
    output logic SERIAL_OUT,
    output logic [11:0] DRIVE_OUT,
    output logic OVERRUN
);
    logic [1:0] sclk_sync;
    logic [1:0] sin_sync;
    logic [1:0] strobe_sync;
    logic [1:0] blank_sync;
    logic sclk_prev;
    logic sclk_rise;
    logic [11:0] shift_reg;
    logic [11:0] latch_reg;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_data;
    logic next_sclk_prev;
    logic next_overrun;
    logic [11:0] next_shift_reg;
    logic [11:0] next_latch_reg;
    logic [11:0] next_drive_out;
    logic next_serial_out;

    // Shift clock synchroniser; only the edge detector reads its second stage
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sclk_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[0], SHIFT_CLK};
        end
    end

    // Data takes the same two stages so it stays aligned with the detected edge
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sin_sync <= 2'h0;
        end else begin
            sin_sync <= {sin_sync[0], SERIAL_IN};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            strobe_sync <= 2'h0;
        end else begin
            strobe_sync <= {strobe_sync[0], LATCH_STROBE};
        end
    end

    // Resets high so the outputs stay off for the first cycles after reset
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            blank_sync <= 2'h3;
        end else begin
            blank_sync <= {blank_sync[0], OUTPUT_BLANK};
        end
    end

    // Idle level of the shift clock is low, so no false edge follows reset
    always_comb begin
        next_sclk_prev = sclk_sync[1];
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= next_sclk_prev;
        end
    end

    // Data delay matches clock delay, so the bit captured is the one set up before the edge
    assign sclk_rise = sclk_sync[1] && !sclk_prev;

    sld_buf u_buf (
        .clk(CLK),
        .resetn(RESETN),
        .in_valid(sclk_rise),
        .in_ready(buf_in_ready),
        .in_data(sin_sync[1]),
        .out_valid(buf_out_valid),
        .out_ready(1'b1),
        .out_data(buf_out_data)
    );

    // Move every stage one place toward the cascade end; the new bit enters stage zero
    function automatic logic [11:0] shift_in(input logic [11:0] stages, input logic bit_in);
        return {stages[sld_pkg::LAST_STAGE-1:0], bit_in};
    endfunction

    // Outputs forced low while blanked, otherwise a copy of the latches
    function automatic logic [11:0] gate_outputs(input logic [11:0] latches, input logic blanked);
        if (blanked) begin
            return 12'h000;
        end
        return latches;
    endfunction

    // Flags an edge arriving while the buffer is full; cannot occur when drain never stalls
    always_comb begin
        next_overrun = OVERRUN;
        if (sclk_rise && !buf_in_ready) begin
            next_overrun = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            OVERRUN <= 1'b0;
        end else begin
            OVERRUN <= next_overrun;
        end
    end

    // A bit leaving the buffer advances the chain by one stage
    always_comb begin
        next_shift_reg = shift_reg;
        if (buf_out_valid) begin
            next_shift_reg = shift_in(shift_reg, buf_out_data);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            shift_reg <= sld_pkg::RESET_VALUE;
        end else begin
            shift_reg <= next_shift_reg;
        end
    end

    // Blanking is not an input here, so it cannot touch the latches
    always_comb begin
        next_latch_reg = latch_reg;
        if (strobe_sync[1]) begin
            next_latch_reg = shift_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            latch_reg <= sld_pkg::RESET_VALUE;
        end else begin
            latch_reg <= next_latch_reg;
        end
    end

    always_comb begin
        next_drive_out = gate_outputs(latch_reg, blank_sync[1]);
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            DRIVE_OUT <= sld_pkg::RESET_VALUE;
        end else begin
            DRIVE_OUT <= next_drive_out;
        end
    end

    // Cascade output for a following device on the same clock and strobe
    always_comb begin
        next_serial_out = shift_reg[sld_pkg::LAST_STAGE];
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            SERIAL_OUT <= 1'b0;
        end else begin
            SERIAL_OUT <= next_serial_out;
        end
    end
endmodule
`default_nettype wire

// ### test/sld_props.sv
// Checker on the driver core ports
`default_nettype none
module sld_props (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SHIFT_CLK,
    input wire logic SERIAL_IN,
    input wire logic LATCH_STROBE,
    input wire logic OUTPUT_BLANK,
    input wire logic SERIAL_OUT,
    input wire logic [11:0] DRIVE_OUT,
    input wire logic OVERRUN
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic on = LATCH_STROBE && !OUTPUT_BLANK;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    property p_b; OUTPUT_BLANK [*5] |-> ~|DRIVE_OUT; endproperty
    a_b: assert property (p_b) else $error("blank");
    property p_l; $rose(OUTPUT_BLANK) |-> ##[1:4] ~|DRIVE_OUT; endproperty
    a_l: assert property (p_l) else $error("late");
    property p_h; !(LATCH_STROBE || OUTPUT_BLANK) [*8] |=> $stable(DRIVE_OUT); endproperty
    a_h: assert property (p_h) else $error("hold");
    property p_s; $stable(SHIFT_CLK) [*8] |=> $stable(SERIAL_OUT); endproperty
    a_s: assert property (p_s) else $error("cascade");
    property p_t; (on && $stable(SHIFT_CLK)) [*8] |-> DRIVE_OUT[11] == SERIAL_OUT; endproperty
    a_t: assert property (p_t) else $error("tail");
    property p_i; $rose(SHIFT_CLK) ##0 (on && $stable(SERIAL_IN)) [*8] |-> DRIVE_OUT[0] == SERIAL_IN; endproperty
    a_i: assert property (p_i) else $error("entry");
    property p_m; on [*8] ##1 $rose(SHIFT_CLK) ##0 on [*8] |-> (DRIVE_OUT >> 1) == ($past(DRIVE_OUT, 7) & 12'h7ff);
    endproperty
    a_m: assert property (p_m) else $error("move");
    property p_o; !OVERRUN; endproperty
    a_o: assert property (p_o) else $error("overrun");
    c_s: cover property ($rose(SHIFT_CLK) && on);
    c_b: cover property ($fell(OUTPUT_BLANK));
    c_h: cover property ($fell(LATCH_STROBE));
endmodule
bind sld_core sld_props u_p (.CLK, .RESETN, .SHIFT_CLK, .SERIAL_IN, .LATCH_STROBE, .OUTPUT_BLANK,
    .SERIAL_OUT, .DRIVE_OUT, .OVERRUN);
`default_nettype wire

// ### test/sld_host.sv
// Host driving shift clock, data, strobe and blanking
`default_nettype none
module sld_host (
    input wire logic clk,
    output logic sck,
    output logic sdi,
    output logic stb,
    output logic blk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial sck = 0;
    initial sdi = 0;
    initial stb = 0;
    initial blk = 1;
    // Most significant bit first; 80 ns shift clock rests low between words
    task automatic send(input logic [11:0] w, input logic s, input logic b);
        stb = s;
        blk = b;
        for (int i = 11; i >= 0; i--) begin
            sdi = w[i];
            repeat (10) @(negedge clk);
            sck = 1;
            repeat (10) @(negedge clk);
            sck = 0;
        end
        sdi = ~w[0];
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Bench for the serial latched driver
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0;
    logic resetn = 0;
    logic sck, sdi, stb, blk, sout;
    logic [11:0] drv, w, n;
    logic [15:0] r = 16'hb5ff;
    int fails = 0;
    int num_checks = 0;
    initial forever #2 clk = ~clk;
    sld_host u_host (.clk, .sck, .sdi, .stb, .blk);
    sld_core u_dut (.CLK(clk), .RESETN(resetn), .SHIFT_CLK(sck), .SERIAL_IN(sdi), .LATCH_STROBE(stb),
        .OUTPUT_BLANK(blk), .SERIAL_OUT(sout), .DRIVE_OUT(drv), .OVERRUN());
    function automatic logic [15:0] rnd(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input string t, input logic [11:0] e, input logic [11:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", t, e, g);
        end
    endtask
    task automatic wt(input logic s, input logic b);
        u_host.stb = s;
        u_host.blk = b;
        repeat (10) @(negedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #100us;
        fails++;
        finish_test();
    end
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1;
        for (int i = 0; i < 8; i++) begin
            w = i == 0 ? 12'hfff : r[11:0];
            r = rnd(r);
            n = r[11:0];
            u_host.send(w, i[0], i[1]);
            wt(1, 0);
            chk("load", w, drv);
            wt(0, 0);
            u_host.send(n, 0, 0);
            wt(0, 0);
            chk("hold", w, drv);
            chk("cascade", {11'h000, n[11]}, {11'h000, sout});
            wt(0, 1);
            chk("blank", 12'h000, drv);
            wt(0, 0);
            chk("unblank", w, drv);
            $display("test %0d done", i);
        end
        finish_test();
    end
endmodule
`default_nettype wire
